// [rtl/i2c_irq_pkg.sv]
package i2c_irq_pkg;

    // Register byte addresses on the peripheral bus
    localparam logic [31:0] TX_THRESHOLD_ADDR   = 32'h5000133C;
    localparam logic [31:0] CLEAR_ALL_ADDR      = 32'h50001340;
    localparam logic [31:0] CLEAR_RX_UNDER_ADDR = 32'h50001344;
    localparam logic [31:0] CLEAR_RX_OVER_ADDR  = 32'h50001348;
    localparam logic [31:0] CLEAR_TX_OVER_ADDR  = 32'h5000134C;
    localparam logic [31:0] CLEAR_RD_REQ_ADDR   = 32'h50001350;
    localparam logic [31:0] CLEAR_TX_ABORT_ADDR = 32'h50001354;

    // Field layout and widths
    localparam int          BUS_W         = 32;
    localparam int          REG_W         = 16;
    localparam int          THR_W         = 5;
    localparam int          LEVEL_W       = 6;
    localparam int          CLEAR_BIT     = 0;
    localparam logic [4:0]  THR_TOP_CODE  = 5'h1F;
    localparam logic [5:0]  THR_TOP_COUNT = 6'h20;
    localparam logic [4:0]  THR_RESET     = 5'h00;
    localparam logic [15:0] REG_RESET     = 16'h0000;

    // Raw interrupt status bit positions
    localparam int RAW_RX_UNDER  = 0;
    localparam int RAW_RX_OVER   = 1;
    localparam int RAW_TX_OVER   = 3;
    localparam int RAW_LOW_WATER = 4;
    localparam int RAW_RD_REQ    = 5;
    localparam int RAW_TX_ABORT  = 6;

    // Abort source record: this bit blocks clearing of the record
    localparam int ABORT_KEEP_BIT = 9;

    // Transmit FIFO depth
    localparam int TX_DEPTH_DEFAULT = 32;

endpackage

// [rtl/sticky_cell.sv]
`timescale 1ns/10ps
module sticky_cell #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    // Set and clear
    input  wire logic         set,
    input  wire logic [W-1:0] set_val,
    input  wire logic         clr,
    // State
    output logic      [W-1:0] q
);

    logic [W-1:0] next_q;

    // Set is applied after clear so an event in the clear cycle survives
    always_comb begin
        next_q = q;
        if (clk_en) begin
            if (clr) begin
                next_q = '0;
            end
            if (set) begin
                next_q = set_val;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule

// [rtl/i2c_tx_threshold_and_irq_clear.sv]
// Notes on behaviour
// - Keep 5-bit transmit threshold; low-water flag set while FIFO level at or below it.
// - Threshold accepts 0..31; oversized writes store the FIFO depth instead.
// - Code 0 means zero entries; code 31 means thirty-two entries.
// - Clear-all read clears combined interrupt, software flags and abort source record.
// - Clear-all read leaves hardware-cleared flags such as low-water untouched.
// - Abort source record is never cleared while its bit 9 is set.
// - Receive-underflow clear read clears raw status bit 0.
// - Receive-overflow clear read clears raw status bit 1.
// - Transmit-overflow clear read clears raw status bit 3.
// - Read-request clear read clears raw status bit 5.
// - Transmit-abort clear read clears raw bit 6 and the abort source record.
// - Transmit-abort clear read releases the flushed transmit FIFO for writes.
// - Clear registers are read-only, bit 0 only, upper bits reserved, reset zero.
// - A transmit abort flushes the FIFO and holds it until the abort clear read.
// - Low-water flag drops by itself once the FIFO level rises above threshold.
// - Transmit FIFO depth is TX_DEPTH, 32 by default, also the saturation value for the threshold.
`timescale 1ns/10ps
module i2c_tx_threshold_and_irq_clear
    import i2c_irq_pkg::*;
#(
    parameter int TX_DEPTH = TX_DEPTH_DEFAULT
) (
    // Clock, reset, enable
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic                clk_en,
    // Peripheral register bus
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [BUS_W-1:0]    paddr,
    input  wire logic [BUS_W-1:0]    pwdata,
    output logic      [BUS_W-1:0]    prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Protocol engine events and FIFO state
    input  wire logic [LEVEL_W-1:0]  tx_fifo_level,
    input  wire logic                rx_underflow_evt,
    input  wire logic                rx_overflow_evt,
    input  wire logic                tx_overflow_evt,
    input  wire logic                read_request_evt,
    input  wire logic                transmit_abort_evt,
    input  wire logic [REG_W-1:0]    abort_source_in,
    // Status towards software and engine
    output logic [REG_W-1:0]         raw_interrupt_status,
    output logic                     tx_fifo_low_water_level,
    output logic                     combined_interrupt,
    output logic [REG_W-1:0]         transmit_abort_source_record,
    output logic                     tx_fifo_flush
);

    // Largest storable code; a full 32 deep FIFO uses the top code
    localparam logic [THR_W-1:0] MAX_CODE =
        (TX_DEPTH == 32) ? THR_TOP_CODE : THR_W'(TX_DEPTH);

    // Depths the 5-bit threshold cannot describe are refused
    if (TX_DEPTH < 1 || TX_DEPTH > 32) begin : g_depth_check
        $error("TX_DEPTH must lie in 1..32");
    end

    logic [THR_W-1:0] threshold;
    logic [THR_W-1:0] next_threshold;
    logic             next_low_water;
    logic [LEVEL_W-1:0] thr_count;
    logic             flag_rx_under;
    logic             flag_rx_over;
    logic             flag_tx_over;
    logic             flag_rd_req;
    logic             flag_tx_abort;
    logic             next_combined;
    logic [BUS_W-1:0] next_prdata;
    logic             next_pslverr;
    logic             next_pready;

    // Bus phase decode; side effects happen only in the access phase
    logic setup_ph;
    logic access_rd;
    logic access_wr;
    logic rd_clr_all;
    logic rd_clr_under;
    logic rd_clr_over;
    logic rd_clr_txover;
    logic rd_clr_rdreq;
    logic rd_clr_abort;
    logic abort_src_clr;

    assign setup_ph      = psel && !penable;
    assign access_rd     = clk_en && psel && penable && pready && !pwrite;
    assign access_wr     = clk_en && psel && penable && pready && pwrite;
    assign rd_clr_all    = access_rd && (paddr == CLEAR_ALL_ADDR);
    assign rd_clr_under  = access_rd && (paddr == CLEAR_RX_UNDER_ADDR);
    assign rd_clr_over   = access_rd && (paddr == CLEAR_RX_OVER_ADDR);
    assign rd_clr_txover = access_rd && (paddr == CLEAR_TX_OVER_ADDR);
    assign rd_clr_rdreq  = access_rd && (paddr == CLEAR_RD_REQ_ADDR);
    assign rd_clr_abort  = access_rd && (paddr == CLEAR_TX_ABORT_ADDR);

    // Record stays while its keep bit is up, whichever clear is read
    assign abort_src_clr = (rd_clr_all || rd_clr_abort)
                         && !transmit_abort_source_record[ABORT_KEEP_BIT];

    // Threshold code to entry count; top code means 32 entries
    assign thr_count = (threshold == THR_TOP_CODE) ? THR_TOP_COUNT
                                                   : {1'b0, threshold};

    // Threshold register and low-water compare
    always_comb begin
        next_threshold = threshold;
        next_low_water = tx_fifo_low_water_level;
        if (clk_en) begin
            if (access_wr && paddr == TX_THRESHOLD_ADDR) begin
                // Only bits 4:0 are kept; oversized values saturate
                next_threshold = (pwdata[THR_W-1:0] > MAX_CODE) ? MAX_CODE
                                                                : pwdata[THR_W-1:0];
            end
            // Level compare both raises and drops the flag, no software clear
            next_low_water = (tx_fifo_level <= thr_count);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            threshold               <= THR_RESET;
            tx_fifo_low_water_level <= 1'b0;
        end else begin
            threshold               <= next_threshold;
            tx_fifo_low_water_level <= next_low_water;
        end
    end

    // Software-clearable flags, each cleared by its own read or by clear-all
    sticky_cell #(.W(1)) u_rx_under (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (rx_underflow_evt),
        .set_val (1'b1),
        .clr     (rd_clr_under || rd_clr_all),
        .q       (flag_rx_under)
    );

    sticky_cell #(.W(1)) u_rx_over (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (rx_overflow_evt),
        .set_val (1'b1),
        .clr     (rd_clr_over || rd_clr_all),
        .q       (flag_rx_over)
    );

    sticky_cell #(.W(1)) u_tx_over (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (tx_overflow_evt),
        .set_val (1'b1),
        .clr     (rd_clr_txover || rd_clr_all),
        .q       (flag_tx_over)
    );

    sticky_cell #(.W(1)) u_rd_req (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (read_request_evt),
        .set_val (1'b1),
        .clr     (rd_clr_rdreq || rd_clr_all),
        .q       (flag_rd_req)
    );

    sticky_cell #(.W(1)) u_tx_abort (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (transmit_abort_evt),
        .set_val (1'b1),
        .clr     (rd_clr_abort || rd_clr_all),
        .q       (flag_tx_abort)
    );

    // Abort source record, loaded by the engine on each abort
    sticky_cell #(.W(REG_W)) u_abort_src (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (transmit_abort_evt),
        .set_val (abort_source_in),
        .clr     (abort_src_clr),
        .q       (transmit_abort_source_record)
    );

    // FIFO held flushed from abort until the abort clear read only
    sticky_cell #(.W(1)) u_flush (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set     (transmit_abort_evt),
        .set_val (1'b1),
        .clr     (rd_clr_abort),
        .q       (tx_fifo_flush)
    );

    // Raw status view; low-water bit is outside the clear-all path
    always_comb begin
        raw_interrupt_status                = REG_RESET;
        raw_interrupt_status[RAW_RX_UNDER]  = flag_rx_under;
        raw_interrupt_status[RAW_RX_OVER]   = flag_rx_over;
        raw_interrupt_status[RAW_TX_OVER]   = flag_tx_over;
        raw_interrupt_status[RAW_LOW_WATER] = tx_fifo_low_water_level;
        raw_interrupt_status[RAW_RD_REQ]    = flag_rd_req;
        raw_interrupt_status[RAW_TX_ABORT]  = flag_tx_abort;
    end

    // Bus answer prepared in setup phase so outputs leave flip-flops
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        next_pready  = 1'b1;
        if (clk_en && setup_ph) begin
            next_prdata  = '0;
            next_pslverr = 1'b0;
            unique case (paddr)
                TX_THRESHOLD_ADDR:   next_prdata[THR_W-1:0] = threshold;
                // Clear registers show the flag they clear in bit 0 only
                CLEAR_ALL_ADDR:      next_prdata[CLEAR_BIT] = combined_interrupt;
                CLEAR_RX_UNDER_ADDR: next_prdata[CLEAR_BIT] = flag_rx_under;
                CLEAR_RX_OVER_ADDR:  next_prdata[CLEAR_BIT] = flag_rx_over;
                CLEAR_TX_OVER_ADDR:  next_prdata[CLEAR_BIT] = flag_tx_over;
                CLEAR_RD_REQ_ADDR:   next_prdata[CLEAR_BIT] = flag_rd_req;
                CLEAR_TX_ABORT_ADDR: next_prdata[CLEAR_BIT] = flag_tx_abort;
                default:             next_pslverr = 1'b1;
            endcase
        end
    end

    // Combined interrupt follows the software flags one cycle late
    assign next_combined = clk_en ? (flag_rx_under | flag_rx_over | flag_tx_over
                                     | flag_rd_req | flag_tx_abort)
                                  : combined_interrupt;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata             <= '0;
            pslverr            <= 1'b0;
            pready             <= 1'b0;
            combined_interrupt <= 1'b0;
        end else begin
            prdata             <= next_prdata;
            pslverr            <= next_pslverr;
            pready             <= next_pready;
            combined_interrupt <= next_combined;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    low_water_cmp_a: assert property (clk_en |=> tx_fifo_low_water_level ==
        ($past(tx_fifo_level) <= (($past(threshold) == THR_TOP_CODE) ? THR_TOP_COUNT
                                  : {1'b0, $past(threshold)})))
        else $error("low-water flag disagrees with level and threshold");

    thr_saturate_a: assert property (access_wr && paddr == TX_THRESHOLD_ADDR
        |=> threshold == (($past(pwdata[THR_W-1:0]) > MAX_CODE) ? MAX_CODE : $past(pwdata[THR_W-1:0])))
        else $error("threshold write not stored or not saturated");

    top_code_full_a: assert property (clk_en && threshold == THR_TOP_CODE
        && tx_fifo_level == THR_TOP_COUNT |=> tx_fifo_low_water_level)
        else $error("top threshold code does not cover 32 entries");

    clear_all_a: assert property (rd_clr_all && !rx_underflow_evt && !rx_overflow_evt
        && !tx_overflow_evt && !read_request_evt && !transmit_abort_evt
        |=> raw_interrupt_status[RAW_TX_ABORT:RAW_RD_REQ] == 2'b00
            && raw_interrupt_status[RAW_TX_OVER:RAW_RX_UNDER] == 4'h0 ##1 !combined_interrupt)
        else $error("clear-all read left a software flag set");

    low_water_kept_a: assert property (rd_clr_all && tx_fifo_low_water_level
        && $stable(tx_fifo_level) && $stable(threshold) |=> tx_fifo_low_water_level)
        else $error("clear-all read dropped the low-water flag");

    abort_keep_a: assert property ((rd_clr_all || rd_clr_abort)
        && transmit_abort_source_record[ABORT_KEEP_BIT] && !transmit_abort_evt
        |=> $stable(transmit_abort_source_record))
        else $error("abort record cleared while keep bit set");

    under_clear_a: assert property (rd_clr_under && !rx_underflow_evt
        |=> !raw_interrupt_status[RAW_RX_UNDER])
        else $error("underflow clear read did not clear bit 0");

    over_clear_a: assert property (rd_clr_over && !rx_overflow_evt && !rx_underflow_evt
        |=> !raw_interrupt_status[RAW_RX_OVER] && $stable(raw_interrupt_status[RAW_RX_UNDER]))
        else $error("overflow clear read wrong");

    txover_clear_a: assert property (rd_clr_txover && !tx_overflow_evt
        |=> !raw_interrupt_status[RAW_TX_OVER])
        else $error("transmit overflow clear read did not clear bit 3");

    rdreq_clear_a: assert property (rd_clr_rdreq && !read_request_evt
        |=> !raw_interrupt_status[RAW_RD_REQ])
        else $error("read request clear read did not clear bit 5");

    abort_clear_a: assert property (rd_clr_abort && !transmit_abort_evt
        && !transmit_abort_source_record[ABORT_KEEP_BIT]
        |=> !raw_interrupt_status[RAW_TX_ABORT] && !tx_fifo_flush
            && transmit_abort_source_record == REG_RESET)
        else $error("abort clear read incomplete");

    flush_hold_a: assert property (clk_en && transmit_abort_evt
        ##1 (!rd_clr_abort) [*3] |-> tx_fifo_flush)
        else $error("transmit FIFO released without abort clear read");

    clear_reg_data_a: assert property (setup_ph && clk_en && paddr >= CLEAR_ALL_ADDR
        && paddr <= CLEAR_TX_ABORT_ADDR && paddr[1:0] == 2'b00 |=> prdata[BUS_W-1:1] == '0 && !pslverr)
        else $error("clear register reserved bits not zero");

    write_ignored_a: assert property (access_wr && paddr != TX_THRESHOLD_ADDR
        |=> $stable(threshold))
        else $error("write to other register changed threshold");

endmodule

// [testbench/tx_fifo_model.sv]
`timescale 1ns/10ps
module tx_fifo_model #(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // Bench controls
    input  wire logic       load,
    input  wire logic [5:0] load_val,
    input  wire logic       push,
    // Flush request from the controller
    input  wire logic       flush,
    // Occupancy seen by the controller
    output logic      [5:0] level
);
    // A flushed FIFO reads empty and refuses every push until released
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            level <= 6'h00;
        end else if (flush) begin
            level <= 6'h00;
        end else if (load) begin
            level <= load_val;
        end else if (push && level < 6'(DEPTH)) begin
            level <= level + 6'h01;
        end
    end
endmodule

// [testbench/i2c_tx_threshold_and_irq_clear_tb.sv]
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %0t %s", $time, msg); end end
module i2c_tx_threshold_and_irq_clear_tb;
    import i2c_irq_pkg::*;
    // Smaller depth so that threshold saturation can be seen
    localparam int DEPTH = 20;
    logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, load, push;
    logic        low_water, combined_interrupt, tx_fifo_flush;
    logic        low_water_full;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] raw, record, src;
    logic [5:0]  level, load_val;
    logic [4:0]  evt;
    logic        er;
    int          n_errors, comparisons;
    // Clear addresses and the raw bit each one drops
    logic [31:0] clr_addr [5] = '{CLEAR_RX_UNDER_ADDR, CLEAR_RX_OVER_ADDR, CLEAR_TX_OVER_ADDR,
                                  CLEAR_RD_REQ_ADDR, CLEAR_TX_ABORT_ADDR};
    int          raw_bit  [5] = '{RAW_RX_UNDER, RAW_RX_OVER, RAW_TX_OVER, RAW_RD_REQ, RAW_TX_ABORT};
    int          thr_tab  [3] = '{0, 7, 19};

    i2c_tx_threshold_and_irq_clear #(.TX_DEPTH(DEPTH)) u_i2c_tx_threshold_and_irq_clear (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_fifo_level(level), .rx_underflow_evt(evt[0]), .rx_overflow_evt(evt[1]),
        .tx_overflow_evt(evt[2]), .read_request_evt(evt[3]), .transmit_abort_evt(evt[4]),
        .abort_source_in(src), .raw_interrupt_status(raw), .tx_fifo_low_water_level(low_water),
        .combined_interrupt(combined_interrupt), .transmit_abort_source_record(record),
        .tx_fifo_flush(tx_fifo_flush));

    // Full-depth unit on the same inputs, for the top threshold code
    i2c_tx_threshold_and_irq_clear u_i2c_tx_threshold_and_irq_clear_full (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .tx_fifo_level(level), .rx_underflow_evt(evt[0]), .rx_overflow_evt(evt[1]),
        .tx_overflow_evt(evt[2]), .read_request_evt(evt[3]), .transmit_abort_evt(evt[4]),
        .abort_source_in(src), .raw_interrupt_status(), .tx_fifo_low_water_level(low_water_full),
        .combined_interrupt(), .transmit_abort_source_record(), .tx_fifo_flush());

    tx_fifo_model #(.DEPTH(DEPTH)) u_tx_fifo_model (
        .sys_clk(sys_clk), .rst_b(rst_b), .load(load), .load_val(load_val), .push(push),
        .flush(tx_fifo_flush), .level(level));

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // One zero-wait transfer; request held until the access edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        psel = 1'b1; penable = 1'b0; pwrite = w; paddr = a; pwdata = d;
        @(negedge sys_clk);
        penable = 1'b1;
        @(posedge sys_clk);
        while (!pready) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        @(negedge sys_clk);
        psel = 1'b0; penable = 1'b0;
    endtask

    // Engine event pulse of one cycle
    task automatic pulse(input logic [4:0] e, input logic [15:0] s);
        @(negedge sys_clk);
        evt = e; src = s;
        @(negedge sys_clk);
        evt = 5'h00;
    endtask

    // Level lands one edge after load, the flag one edge later
    task automatic set_level(input logic [5:0] v);
        @(negedge sys_clk);
        load = 1'b1; load_val = v;
        @(negedge sys_clk);
        load = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog at 40000 cycles, well past the under two hundred cycles the tests need
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    initial begin
        sys_clk = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0;
        pwdata = 32'h0; evt = 5'h00; src = 16'h0000; load = 1'b0; load_val = 6'h00; push = 1'b0;
        n_errors = 0; comparisons = 0;
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
        // Reset state: only low-water up, as empty is at or below zero
        `CHK(raw, 16'h0010, "raw status after reset")
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, TX_THRESHOLD_ADDR + 32'(4 * i), 32'h0);
            `CHK({er, rd}, 33'h0, "register reset read")
        end
        // Threshold with reserved bits set, flag on both sides of it
        foreach (thr_tab[t]) begin
            bus(1'b1, TX_THRESHOLD_ADDR, 32'hFFFFFFE0 | 32'(thr_tab[t]));
            bus(1'b0, TX_THRESHOLD_ADDR, 32'h0);
            `CHK(rd, 32'(thr_tab[t]), "threshold readback")
            set_level(6'(thr_tab[t]));
            `CHK(low_water, 1'b1, "low-water at threshold")
            set_level(6'(thr_tab[t] + 1));
            `CHK(low_water, 1'b0, "low-water above threshold")
            `CHK(raw[RAW_LOW_WATER], 1'b0, "raw low-water bit")
        end
        // Oversized threshold saturates at the depth
        bus(1'b1, TX_THRESHOLD_ADDR, 32'h19);
        bus(1'b0, TX_THRESHOLD_ADDR, 32'h0);
        `CHK(rd, 32'(DEPTH), "threshold saturation")
        // Top code: 32 entries on the full-depth unit, saturated on the small one
        bus(1'b1, TX_THRESHOLD_ADDR, 32'h1F);
        bus(1'b0, TX_THRESHOLD_ADDR, 32'h0);
        `CHK(rd, 32'(DEPTH), "top code saturation")
        set_level(6'h20);
        `CHK({low_water_full, low_water}, 2'b10, "top code covers 32 entries")
        set_level(6'h00);
        // Each single clear register against its own flag
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i, 16'h0001);
            @(negedge sys_clk);
            `CHK(raw[raw_bit[i]] & combined_interrupt, 1'b1, "flag set")
            if (i == 4) begin
                push = 1'b1;
                repeat (2) @(negedge sys_clk);
                push = 1'b0;
                `CHK({tx_fifo_flush, level}, 7'h40, "flushed FIFO refuses")
            end
            bus(1'b1, clr_addr[i], 32'h1);
            `CHK(raw[raw_bit[i]], 1'b1, "write to clear ignored")
            bus(1'b0, clr_addr[i], 32'h0);
            `CHK(rd, 32'h1, "clear read shows flag")
            `CHK(raw[raw_bit[i]], 1'b0, "flag cleared")
            @(negedge sys_clk);
            `CHK(combined_interrupt, 1'b0, "combined drop")
        end
        `CHK({tx_fifo_flush, record}, 17'h0, "abort clear releases")
        // Clear-all leaves low-water and flush alone
        pulse(5'h1F, 16'h00A5);
        @(negedge sys_clk);
        `CHK({raw, record}, 32'h007B00A5, "all flags and record")
        bus(1'b0, CLEAR_ALL_ADDR, 32'h0);
        `CHK(rd, 32'h1, "clear-all read shows combined")
        @(negedge sys_clk);
        `CHK({combined_interrupt, raw, record}, 33'h00100000, "clear-all result")
        `CHK(tx_fifo_flush, 1'b1, "flush kept by clear-all")
        bus(1'b0, CLEAR_TX_ABORT_ADDR, 32'h0);
        `CHK(tx_fifo_flush, 1'b0, "flush released")
        // Record with its keep bit survives both clears
        pulse(5'h10, 16'h0201);
        bus(1'b0, CLEAR_ALL_ADDR, 32'h0);
        `CHK(record, 16'h0201, "record kept by clear-all")
        pulse(5'h10, 16'h0201);
        bus(1'b0, CLEAR_TX_ABORT_ADDR, 32'h0);
        `CHK({tx_fifo_flush, raw[RAW_TX_ABORT], record}, 18'h00201, "record kept")
        // Unmapped address answers with an error and zero
        bus(1'b0, 32'h50001358, 32'h0);
        `CHK({er, rd}, 33'h100000000, "unmapped read")
        give_verdict();
    end
endmodule
